// file: core/crpc_core_seq.sv
// machine cycle, power mode and reset sequencer of an 8-bit core
// assumes one 125 MHz clock; processor, interrupt and watchdog logic sit outside
// Operation
// [RL1] four states per machine cycle, in order
// [RL2] one opcode fetch per machine cycle
// [RL3] data move: fetch cycle, then access cycle
// [RL4] stretch field gives stretch plus two cycles
// [RL5] strobe two clocks, else four per step
// [RL6] stretch holds processor, nothing else changes
// [RL7] stretch field resets to one
// [RL8] idle bit enters idle after instruction
// [RL9] idle stops processor clock, peripherals run
// [RL10] idle drives strobes high, ports hold
// [RL11] enabled interrupt ends idle, clears bit
// [RL12] reset in idle restarts at zero now
// [RL13] power-down bit stops all clocks
// [RL14] power-down drives strobes low
// [RL15] reset pin ends power-down, restarts at zero
// [RL16] level low enabled pin wakes power-down
// [RL17] reset pin sampled in state four
// [RL18] internal reset applied synchronously
// [RL19] reset lasts two cycles after pin falls
// [RL20] software clears power-on flag after reading
// [RL21] supply loss repeats power-on delay, flag
// [RL22] watchdog reset 512 clocks after time-out
// [RL23] watchdog flags reset by source
// [RL24] both mode bits mean power-down
`timescale 1ns/1ps
`default_nettype none
module crpc_core_seq
  import crpc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // asynchronous pins
  input wire logic rstPin,
  input wire logic supplyLow,
  input wire logic [1:0] extIntN,
  // processor handshakes
  input wire logic instrDone,
  input wire logic xmoveReq,
  input wire logic xmoveWrite,
  input wire logic anyIntReq,
  input wire logic extProgMem,
  // interrupt configuration
  input wire logic globalIntEnable,
  input wire logic [1:0] intEnable,
  input wire logic [1:0] intLevelMode,
  // register writes
  input wire logic clkCtrlWe,
  input wire logic [2:0] clkCtrlWdata,
  input wire logic pwrCtrlWe,
  input wire logic [1:0] pwrCtrlWdata,
  input wire logic wdCtrlWe,
  input wire logic [7:0] wdCtrlWdata,
  // watchdog events
  input wire logic wdTimeout,
  input wire logic wdRestart,
  // sequencing outputs
  output logic [1:0] machState,
  output logic fetchStrobe,
  output logic coreReset,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic cpuHold,
  // external data move pins
  output logic xAddrDrive,
  output logic readStrobe,
  output logic writeStrobe,
  // pin overrides in low power modes
  output logic pinForce,
  output logic aleLevel,
  output logic psenLevel,
  output logic port0Float,
  output logic port2Address,
  output logic portHold,
  // register contents
  output logic [2:0] stretchSelect,
  output logic idleRequestBit,
  output logic powerDownRequestBit,
  output logic idleMode,
  output logic powerDownMode,
  output logic porFlag,
  output logic wdResetFlag,
  output logic wdResetEnable
);

  typedef struct packed {
    crpc_phase_t phase;
    crpc_mode_t mode;
    logic fetchCycle;
    logic [2:0] stretch;
    logic idleBit;
    logic pdBit;
    logic rstSeen;
    logic [3:0] rstTail;
    logic porBusy;
    logic [7:0] porCnt;
    logic wdArmed;
    logic [9:0] wdCnt;
    logic [3:0] wdRstCnt;
    logic porFlag;
    logic wtrf;
    logic ewt;
  } crpc_seq_st_t;

  crpc_seq_st_t st_r, st_nxt;
  logic [3:0] pinSync;
  logic rstS;
  logic supplyS;
  logic [1:0] intNS;
  logic [1:0] pinWake;
  logic coreRst;
  logic xBusy;
  logic xHold;
  logic xStart;
  logic fetchNow;

  // true when interrupts are globally enabled and an enabled, level-mode external pin is held low
  function automatic logic levelWake(input logic gie, input logic [1:0] wake);
    levelWake = gie && (wake != 2'h0);
  endfunction

  // ==========================================================
  // pin synchronisers
  crpc_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din({extIntN, supplyLow, rstPin}),
    .dout(pinSync)
  );

  assign rstS = pinSync[SYNC_RST_PIN];
  assign supplyS = pinSync[SYNC_SUPPLY];
  assign intNS = pinSync[SYNC_INT_LSB +: 2];

  // per pin wake qualification
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_wake
      assign pinWake[gi] = intEnable[gi] && intLevelMode[gi] && !intNS[gi];
    end
  endgenerate

  // ==========================================================
  // internal reset is a clocked combination of all sources
  assign coreRst = st_r.porBusy || st_r.rstSeen || (st_r.rstTail != 4'h0)
                   || (st_r.wdRstCnt != 4'h0); // see [RL18]

  // one fetch in state one of a running cycle, outside reset and with no data move access busy
  assign fetchNow = (st_r.phase == PH_ONE) && (st_r.mode == MD_RUN)
                    && !coreRst && !xBusy; // see [RL2]

  // data move access starts after its own fetch cycle
  assign xStart = (st_r.phase == PH_FOUR) && st_r.fetchCycle && xmoveReq
                  && (st_r.mode == MD_RUN) && !coreRst; // see [RL3]

  // ==========================================================
  // external data move timer
  crpc_xmove_timer u_xmove (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .syncRst(coreRst),
    .start(xStart),
    .isWrite(xmoveWrite),
    .stretchSel(st_r.stretch),
    .busy(xBusy),
    .cpuHold(xHold),
    .addrDrive(xAddrDrive),
    .rdStrobe(readStrobe),
    .wrStrobe(writeStrobe)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // free-running phase counter
    case (st_r.phase)
      PH_ONE: st_nxt.phase = PH_TWO; // see [RL1]
      PH_TWO: st_nxt.phase = PH_THREE;
      PH_THREE: st_nxt.phase = PH_FOUR;
      PH_FOUR: st_nxt.phase = PH_ONE;
      default: st_nxt.phase = PH_ONE;
    endcase
    if (st_r.phase == PH_ONE) begin
      st_nxt.fetchCycle = fetchNow;
    end

    // reset pin seen only in state four
    if (st_r.phase == PH_FOUR) begin
      if (rstS) begin
        st_nxt.rstSeen = 1'b1; // see [RL17]
      end else if (st_r.rstSeen) begin
        st_nxt.rstSeen = 1'b0;
        st_nxt.rstTail = RST_TAIL_CLKS; // see [RL19]
      end
    end
    if (st_r.rstTail != 4'h0) begin
      st_nxt.rstTail = st_r.rstTail - 4'h1;
    end

    // power-on delay countdown
    if (st_r.porBusy) begin
      if (st_r.porCnt == 8'h00) begin
        st_nxt.porBusy = 1'b0;
      end else begin
        st_nxt.porCnt = st_r.porCnt - 8'h01;
      end
    end

    // watchdog reset hold countdown
    if (st_r.wdRstCnt != 4'h0) begin
      st_nxt.wdRstCnt = st_r.wdRstCnt - 4'h1;
    end

    // software register writes
    if (clkCtrlWe) begin
      st_nxt.stretch = clkCtrlWdata;
    end
    if (pwrCtrlWe) begin
      st_nxt.idleBit = pwrCtrlWdata[IDLE_BIT];
      st_nxt.pdBit = pwrCtrlWdata[PDOWN_BIT];
    end
    if (wdCtrlWe) begin
      st_nxt.porFlag = wdCtrlWdata[WD_POR_BIT]; // see [RL20]
      st_nxt.wtrf = wdCtrlWdata[WD_WTRF_BIT];
      st_nxt.ewt = wdCtrlWdata[WD_EWT_BIT];
    end

    // watchdog reset follows a time-out unless restarted
    if (wdTimeout) begin
      st_nxt.wdArmed = 1'b1;
      st_nxt.wdCnt = WD_RST_DELAY - 10'h001;
    end else if (wdRestart) begin
      st_nxt.wdArmed = 1'b0;
    end else if (st_r.wdArmed && (st_r.mode != MD_PDOWN)) begin // see [RL13]
      if (st_r.wdCnt == 10'h000) begin
        st_nxt.wdArmed = 1'b0;
        if (st_r.ewt) begin
          st_nxt.wdRstCnt = RST_TAIL_CLKS; // see [RL22]
          st_nxt.wtrf = 1'b1; // see [RL23]
        end
      end else begin
        st_nxt.wdCnt = st_r.wdCnt - 10'h001;
      end
    end

    // mode sequencing
    case (st_r.mode)
      MD_RUN: begin
        if (instrDone && st_nxt.pdBit) begin
          st_nxt.mode = MD_PDOWN; // see [RL13] [RL24]
        end else if (instrDone && st_nxt.idleBit) begin
          st_nxt.mode = MD_IDLE; // see [RL8]
        end
      end
      MD_IDLE: begin
        if (anyIntReq) begin
          st_nxt.mode = MD_RUN; // see [RL11]
          st_nxt.idleBit = 1'b0;
        end
      end
      MD_PDOWN: begin
        if (levelWake(globalIntEnable, pinWake)) begin
          st_nxt.mode = MD_RUN; // see [RL16]
          st_nxt.pdBit = 1'b0;
        end
      end
      default: st_nxt.mode = MD_RUN;
    endcase

    // any reset returns to run at once and clears control state
    if (coreRst) begin
      st_nxt.mode = MD_RUN; // see [RL12] [RL15]
      st_nxt.idleBit = 1'b0;
      st_nxt.pdBit = 1'b0;
      st_nxt.stretch = STRETCH_RST; // see [RL7]
      st_nxt.fetchCycle = 1'b0;
      st_nxt.wdArmed = 1'b0;
    end

    // supply loss repeats the power-on sequence and wins over writes
    if (supplyS) begin
      st_nxt.porBusy = 1'b1; // see [RL21]
      st_nxt.porCnt = POR_DELAY_CNT;
      st_nxt.porFlag = WATCHDOG_CONTROL_REG_POR_VAL[WD_POR_BIT]; // see [RL23]
      st_nxt.wtrf = WATCHDOG_CONTROL_REG_POR_VAL[WD_WTRF_BIT];
      st_nxt.ewt = WATCHDOG_CONTROL_REG_POR_VAL[WD_EWT_BIT];
    end
  end

  // ==========================================================
  // state register, power-on values under the asynchronous reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.phase <= PH_ONE;
      st_r.mode <= MD_RUN;
      st_r.stretch <= STRETCH_RST;
      st_r.porBusy <= 1'b1;
      st_r.porCnt <= POR_DELAY_CNT;
      st_r.porFlag <= WATCHDOG_CONTROL_REG_POR_VAL[WD_POR_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // clock gating and sequencing outputs
  assign machState = st_r.phase;
  assign fetchStrobe = fetchNow;
  assign coreReset = coreRst;
  assign cpuHold = xHold;
  assign cpuClkEn = (st_r.mode == MD_RUN) && !xHold; // see [RL6] [RL9]
  assign periphClkEn = (st_r.mode != MD_PDOWN); // see [RL13]

  // pin levels in idle and power-down
  assign pinForce = (st_r.mode != MD_RUN);
  assign aleLevel = (st_r.mode == MD_IDLE); // see [RL10] [RL14]
  assign psenLevel = (st_r.mode == MD_IDLE);
  assign port0Float = pinForce && extProgMem;
  assign port2Address = (st_r.mode == MD_IDLE) && extProgMem;
  assign portHold = pinForce;

  // register contents
  assign stretchSelect = st_r.stretch; // see [RL4]
  assign idleRequestBit = st_r.idleBit;
  assign powerDownRequestBit = st_r.pdBit;
  assign idleMode = (st_r.mode == MD_IDLE);
  assign powerDownMode = (st_r.mode == MD_PDOWN);
  assign porFlag = st_r.porFlag;
  assign wdResetFlag = st_r.wtrf;
  assign wdResetEnable = st_r.ewt;

  // ==========================================================
  // checks
  a_phase_order: assert property ( // see [RL1]
    @(posedge ref_clk) disable iff (!arst_n)
    machState == 2'(PH_ONE) |=> machState == 2'(PH_TWO) ##1 machState == 2'(PH_THREE)
      ##1 machState == 2'(PH_FOUR) ##1 machState == 2'(PH_ONE))
    else $error("machine phases out of order");

  a_fetch_once: assert property ( // see [RL2]
    @(posedge ref_clk) disable iff (!arst_n)
    fetchStrobe |-> machState == 2'(PH_ONE) ##1 !fetchStrobe [*3])
    else $error("more than one fetch in a machine cycle");

  a_access_start: assert property ( // see [RL3]
    @(posedge ref_clk) disable iff (!arst_n)
    xStart |=> xAddrDrive && machState == 2'(PH_ONE) && !fetchStrobe)
    else $error("access cycle did not follow the fetch");

  a_stretch_len: assert property ( // see [RL4]
    @(posedge ref_clk) disable iff (!arst_n)
    xStart && stretchSelect == 3'h1 && !clkCtrlWe |=> xAddrDrive [*8] ##1 !xAddrDrive)
    else $error("access length wrong for stretch one");

  a_strobe_zero: assert property ( // see [RL5]
    @(posedge ref_clk) disable iff (!arst_n)
    xStart && stretchSelect == 3'h0 |=> !(readStrobe || writeStrobe)
      ##1 (readStrobe || writeStrobe) [*2] ##1 !(readStrobe || writeStrobe))
    else $error("strobe not two clocks at zero stretch");

  a_hold_in_move: assert property ( // see [RL6]
    @(posedge ref_clk) disable iff (!arst_n)
    cpuHold |-> xAddrDrive && !cpuClkEn)
    else $error("processor held outside a data move");

  a_reset_stretch: assert property ( // see [RL7]
    @(posedge ref_clk) disable iff (!arst_n)
    $fell(coreReset) |-> stretchSelect == STRETCH_RST)
    else $error("stretch field not one after reset");

  a_idle_pins: assert property ( // see [RL10]
    @(posedge ref_clk) disable iff (!arst_n)
    idleMode |-> pinForce && aleLevel && psenLevel && periphClkEn && !cpuClkEn)
    else $error("idle pin or clock state wrong");

  a_pdown_pins: assert property ( // see [RL14]
    @(posedge ref_clk) disable iff (!arst_n)
    powerDownMode |-> pinForce && !aleLevel && !psenLevel && !periphClkEn)
    else $error("power-down pin or clock state wrong");

  a_idle_wake: assert property ( // see [RL11]
    @(posedge ref_clk) disable iff (!arst_n)
    idleMode && anyIntReq && !coreReset |=> !idleMode && !idleRequestBit)
    else $error("interrupt did not end idle");

  a_pdown_prio: assert property ( // see [RL24]
    @(posedge ref_clk) disable iff (!arst_n)
    !idleMode && !powerDownMode && pwrCtrlWe && pwrCtrlWdata == 2'h3 && instrDone
      && !coreReset && !supplyS |=> powerDownMode)
    else $error("both mode bits did not give power-down");

  a_level_wake: assert property ( // see [RL16]
    @(posedge ref_clk) disable iff (!arst_n)
    powerDownMode && levelWake(globalIntEnable, pinWake) |=> !powerDownMode)
    else $error("level interrupt did not end power-down");

  a_reset_tail: assert property ( // see [RL19]
    @(posedge ref_clk) disable iff (!arst_n)
    $fell(st_r.rstSeen) && !st_r.porBusy && st_r.wdRstCnt == 4'h0 && !supplyS
      |-> coreReset [*8] ##1 (!coreReset || st_r.rstSeen || st_r.porBusy || st_r.wdRstCnt != 4'h0))
    else $error("reset tail not two machine cycles");

endmodule // crpc_core_seq
`default_nettype wire

// file: common/crpc_pkg.sv
// constants and types shared by the core cycle, power and reset sequencer
// assumes a single 125 MHz ref_clk domain
package crpc_pkg;

  // ==========================================================
  // machine cycle phases and power modes
  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} crpc_phase_t;
  typedef enum logic [1:0] {MD_RUN, MD_IDLE, MD_PDOWN} crpc_mode_t;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int POR_DELAY_NS = 2000;
  localparam int POR_DELAY_CLKS = (POR_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] POR_DELAY_CNT = 8'(POR_DELAY_CLKS - 1);
  localparam logic [3:0] RST_TAIL_CLKS = 4'h8;
  localparam logic [9:0] WD_RST_DELAY = 10'h200;

  // ==========================================================
  // register fields and reset values
  localparam logic [2:0] STRETCH_RST = 3'h1;
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam int WD_EWT_BIT = 1;
  localparam int WD_WTRF_BIT = 2;
  localparam int WD_POR_BIT = 6;
  localparam logic [7:0] WATCHDOG_CONTROL_REG_POR_VAL = 8'h40;

  // ==========================================================
  // strobe window limits and processor hold start inside the access phase, in clocks
  localparam logic [4:0] XS_BEGIN_ZERO = 5'h01;
  localparam logic [4:0] XS_END_ZERO = 5'h03;
  localparam logic [4:0] XS_BEGIN_N = 5'h02;
  localparam logic [4:0] XS_HOLD_FROM = 5'h04;

  // ==========================================================
  // synchroniser lanes
  localparam logic [3:0] SYNC_RST_VAL = 4'hC;
  localparam int SYNC_RST_PIN = 0;
  localparam int SYNC_SUPPLY = 1;
  localparam int SYNC_INT_LSB = 2;

endpackage

// file: core/crpc_sync.sv
// two-flop synchroniser for the asynchronous pins of the sequencer
// assumes pins are unrelated to ref_clk
`timescale 1ns/1ps
`default_nettype none
module crpc_sync
  import crpc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // pins in, synchronised out
  input wire logic [3:0] din,
  output logic [3:0] dout
);

  typedef struct packed {
    logic [3:0] stage1;
    logic [3:0] stage2;
  } crpc_sync_st_t;

  crpc_sync_st_t st_r, st_nxt;

  // ==========================================================
  // first stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage1 = din;
    st_nxt.stage2 = st_r.stage1;
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= {SYNC_RST_VAL, SYNC_RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stage2;

endmodule // crpc_sync
`default_nettype wire

// file: core/crpc_xmove_timer.sv
// access phase timer of an external data move: address, strobes, hold
// assumes start arrives in state four of the fetch cycle
`timescale 1ns/1ps
`default_nettype none
module crpc_xmove_timer
  import crpc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic syncRst,
  // request
  input wire logic start,
  input wire logic isWrite,
  input wire logic [2:0] stretchSel,
  // status and pins
  output logic busy,
  output logic cpuHold,
  output logic addrDrive,
  output logic rdStrobe,
  output logic wrStrobe
);

  typedef struct packed {
    logic active;
    logic write;
    logic [4:0] cnt;
    logic [4:0] last;
    logic [4:0] sBegin;
    logic [4:0] sEnd;
    logic addr;
    logic rd;
    logic wr;
  } crpc_xm_st_t;

  crpc_xm_st_t st_r, st_nxt;
  logic win;

  // ==========================================================
  // access phase lasts four clocks per stretch step plus one cycle
  always_comb begin
    st_nxt = st_r;
    win = 1'b0;
    if (syncRst) begin
      st_nxt = '0;
    end else if (st_r.active) begin
      if (st_r.cnt == st_r.last) begin
        st_nxt.active = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end else if (start) begin
      st_nxt.active = 1'b1;
      st_nxt.write = isWrite;
      st_nxt.cnt = '0;
      st_nxt.last = {stretchSel, 2'b11}; // see [RL4]
      // strobe two clocks at zero stretch, else four per step
      st_nxt.sBegin = (stretchSel == 3'h0) ? XS_BEGIN_ZERO : XS_BEGIN_N;
      st_nxt.sEnd = (stretchSel == 3'h0) ? XS_END_ZERO : {stretchSel, 2'b10}; // see [RL5]
    end
    win = st_nxt.active && (st_nxt.cnt >= st_nxt.sBegin) && (st_nxt.cnt < st_nxt.sEnd);
    st_nxt.addr = st_nxt.active;
    st_nxt.rd = win && !st_nxt.write;
    st_nxt.wr = win && st_nxt.write;
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign busy = st_r.active;
  assign cpuHold = st_r.active && (st_r.cnt >= XS_HOLD_FROM);
  assign addrDrive = st_r.addr;
  assign rdStrobe = st_r.rd;
  assign wrStrobe = st_r.wr;

endmodule // crpc_xmove_timer
`default_nettype wire

// file: sim/crpc_xmem_model.sv
// far-side external data memory: measures strobe and address windows
// assumes strobes and address drive are registers on ref_clk
`timescale 1ns/1ps
`default_nettype none
module crpc_xmem_model (
  // clock
  input wire logic ref_clk,
  // pins from the sequencer
  input wire logic xAddrDrive,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  // last measured widths in clocks
  output logic [7:0] rdWidth,
  output logic [7:0] wrWidth,
  output logic [7:0] addrWidth
);
  // ==========================================================
  // width counters
  logic [7:0] rdCnt;
  logic [7:0] wrCnt;
  logic [7:0] adCnt;
  initial begin
    {rdCnt, wrCnt, adCnt, rdWidth, wrWidth, addrWidth} = '0;
  end
  // each width is recorded once its strobe or the address drive closes
  always @(posedge ref_clk) begin
    rdCnt <= readStrobe ? rdCnt + 8'h01 : 8'h00;
    wrCnt <= writeStrobe ? wrCnt + 8'h01 : 8'h00;
    adCnt <= xAddrDrive ? adCnt + 8'h01 : 8'h00;
    if (!readStrobe && rdCnt != 8'h00) rdWidth <= rdCnt;
    if (!writeStrobe && wrCnt != 8'h00) wrWidth <= wrCnt;
    if (!xAddrDrive && adCnt != 8'h00) addrWidth <= adCnt;
  end
endmodule // crpc_xmem_model
`default_nettype wire

// file: sim/crpc_core_seq_tb.sv
// self-checking bench for the cycle, power and reset sequencer
// assumes crpc_pkg, crpc_core_seq and crpc_xmem_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module crpc_core_seq_tb;
  import crpc_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic ref_clk, arst_n, rstPin, supplyLow, instrDone, xmoveReq, xmoveWrite;
  logic anyIntReq, extProgMem, globalIntEnable, clkCtrlWe, pwrCtrlWe;
  logic wdCtrlWe, wdTimeout, wdRestart;
  logic [1:0] extIntN, intEnable, intLevelMode, pwrCtrlWdata, machState;
  logic [2:0] clkCtrlWdata, stretchSelect;
  logic [7:0] wdCtrlWdata, rdWidth, wrWidth, addrWidth;
  logic fetchStrobe, coreReset, cpuClkEn, periphClkEn, cpuHold, xAddrDrive;
  logic readStrobe, writeStrobe, pinForce, aleLevel, psenLevel, port0Float;
  logic port2Address, portHold, idleRequestBit, powerDownRequestBit;
  logic idleMode, powerDownMode, porFlag, wdResetFlag, wdResetEnable;
  int nErrors = 0;
  int numChecks = 0;

  crpc_core_seq uut (.ref_clk(ref_clk), .arst_n(arst_n), .rstPin(rstPin),
    .supplyLow(supplyLow), .extIntN(extIntN), .instrDone(instrDone),
    .xmoveReq(xmoveReq), .xmoveWrite(xmoveWrite), .anyIntReq(anyIntReq),
    .extProgMem(extProgMem), .globalIntEnable(globalIntEnable),
    .intEnable(intEnable), .intLevelMode(intLevelMode), .clkCtrlWe(clkCtrlWe),
    .clkCtrlWdata(clkCtrlWdata), .pwrCtrlWe(pwrCtrlWe),
    .pwrCtrlWdata(pwrCtrlWdata), .wdCtrlWe(wdCtrlWe), .wdCtrlWdata(wdCtrlWdata),
    .wdTimeout(wdTimeout), .wdRestart(wdRestart), .machState(machState),
    .fetchStrobe(fetchStrobe), .coreReset(coreReset), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .cpuHold(cpuHold), .xAddrDrive(xAddrDrive),
    .readStrobe(readStrobe), .writeStrobe(writeStrobe), .pinForce(pinForce),
    .aleLevel(aleLevel), .psenLevel(psenLevel), .port0Float(port0Float),
    .port2Address(port2Address), .portHold(portHold),
    .stretchSelect(stretchSelect), .idleRequestBit(idleRequestBit),
    .powerDownRequestBit(powerDownRequestBit), .idleMode(idleMode),
    .powerDownMode(powerDownMode), .porFlag(porFlag),
    .wdResetFlag(wdResetFlag), .wdResetEnable(wdResetEnable));

  crpc_xmem_model mem (.ref_clk(ref_clk), .xAddrDrive(xAddrDrive),
    .readStrobe(readStrobe), .writeStrobe(writeStrobe), .rdWidth(rdWidth),
    .wrWidth(wrWidth), .addrWidth(addrWidth));

  // ==========================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #60us;
    nErrors++;
    stop_test();
  end

  // ==========================================================
  // compare and helper tasks
  task automatic chk_bit(string what, logic exp, logic got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_val(string what, logic [7:0] exp, logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic clks(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // waits for reset (pd 0) or power-down (pd 1) to reach a level, at most lim clocks
  task automatic wait_for(bit pd, logic lvl, int lim, string what);
    int i;
    for (i = 0; i < lim && (pd ? powerDownMode : coreReset) !== lvl; i++) clks(1);
    chk_bit(what, lvl, pd ? powerDownMode : coreReset);
  endtask
  task automatic wd_write(logic [7:0] bits);
    wdCtrlWe = 1'b1;
    wdCtrlWdata = bits;
    clks(1);
    wdCtrlWe = 1'b0;
  endtask
  task automatic pwr_write(logic [1:0] bits);
    pwrCtrlWe = 1'b1;
    pwrCtrlWdata = bits;
    instrDone = 1'b1;
    clks(1);
    {pwrCtrlWe, instrDone} = 2'b00;
  endtask
  // pin high long enough for a state-four sample, then released
  task automatic pin_reset();
    rstPin = 1'b1;
    clks(12);
    rstPin = 1'b0;
    wait_for(1'b0, 1'b0, 16, "pin reset end");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk_bit("reset held", 1'b1, coreReset);
    chk_val("stretch reset", 8'(STRETCH_RST), 8'(stretchSelect));
    chk_bit("por flag", 1'b1, porFlag);
    chk_bit("wd flag", 1'b0, wdResetFlag);
    wait_for(1'b0, 1'b0, 300, "power-on reset end");
    $display("test reset done");
  endtask
  task automatic t_phases();
    logic [1:0] prev;
    prev = machState;
    repeat (9) begin
      clks(1);
      chk_val("phase step", 8'(2'(prev + 2'h1)), 8'(machState));
      chk_bit("fetch in state one", machState == 2'h0, fetchStrobe);
      prev = machState;
    end
    $display("test phases done");
  endtask
  task automatic t_xmove(logic [2:0] n, logic wr);
    clkCtrlWe = 1'b1;
    clkCtrlWdata = n;
    clks(1);
    clkCtrlWe = 1'b0;
    while (machState !== 2'h3) clks(1);
    {xmoveReq, xmoveWrite} = {1'b1, wr};
    clks(1);
    xmoveReq = 1'b0;
    clks(4 * n + 10);
    chk_val("address window", 8'(4 * (n + 1)), addrWidth);
    chk_val("strobe width", (n == 0) ? 8'h02 : 8'(4 * n), wr ? wrWidth : rdWidth);
    chk_bit("hold released", 1'b0, cpuHold);
    $display("test data move %0d done", n);
  endtask
  task automatic t_idle();
    pwr_write(2'b01);
    chk_bit("idle entered", 1'b1, idleMode);
    chk_bit("cpu clock off", 1'b0, cpuClkEn);
    chk_bit("periph clock on", 1'b1, periphClkEn);
    chk_bit("idle ale", 1'b1, aleLevel & pinForce & portHold);
    chk_bit("idle program_store_strobe", 1'b1, psenLevel);
    chk_bit("idle port0", 1'b1, port0Float & port2Address);
    anyIntReq = 1'b1;
    clks(2);
    anyIntReq = 1'b0;
    chk_bit("idle woken", 1'b0, idleMode | idleRequestBit);
    pwr_write(2'b01);
    rstPin = 1'b1;
    wait_for(1'b0, 1'b1, 10, "reset in idle");
    clks(1);
    chk_bit("idle left on reset", 1'b0, idleMode);
    pin_reset();
    chk_bit("flags kept", 1'b1, porFlag & ~wdResetFlag);
    wd_write(8'h00);
    chk_bit("por flag cleared", 1'b0, porFlag);
    $display("test idle done");
  endtask
  task automatic t_pdown();
    {intEnable, intLevelMode, globalIntEnable} = 5'b01010;
    pwr_write(2'b11);
    chk_bit("both bits pdown", 1'b1, powerDownMode & ~idleMode);
    chk_bit("all clocks off", 1'b0, periphClkEn | cpuClkEn);
    chk_bit("pdown pins", 1'b0, aleLevel | psenLevel);
    extIntN = 2'b10;
    clks(8);
    chk_bit("no wake without enable", 1'b1, powerDownMode);
    extIntN = 2'b11;
    pin_reset();
    chk_bit("pin ends pdown", 1'b0, powerDownMode);
    globalIntEnable = 1'b1;
    pwr_write(2'b10);
    extIntN = 2'b10;
    wait_for(1'b1, 1'b0, 8, "level wake");
    chk_bit("pdown bit cleared", 1'b0, powerDownRequestBit);
    extIntN = 2'b11;
    $display("test power-down done");
  endtask
  task automatic t_wdog();
    wd_write(8'h02);
    wdTimeout = 1'b1;
    clks(1);
    wdTimeout = 1'b0;
    clks(511);
    chk_bit("early wd reset", 1'b0, coreReset);
    clks(1);
    chk_bit("wd reset", 1'b1, coreReset & wdResetFlag & wdResetEnable);
    wait_for(1'b0, 1'b0, 10, "wd reset end");
    supplyLow = 1'b1;
    clks(3);
    supplyLow = 1'b0;
    chk_bit("supply reset", 1'b1, coreReset & porFlag);
    chk_bit("supply wd bits", 1'b0, wdResetFlag | wdResetEnable);
    wait_for(1'b0, 1'b0, 300, "supply reset end");
    $display("test watchdog done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {arst_n, rstPin, supplyLow, instrDone, xmoveReq, xmoveWrite} = '0;
    {anyIntReq, globalIntEnable, clkCtrlWe, pwrCtrlWe, wdCtrlWe} = '0;
    {wdTimeout, wdRestart, intEnable, intLevelMode, pwrCtrlWdata} = '0;
    {clkCtrlWdata, wdCtrlWdata} = '0;
    extIntN = 2'b11;
    extProgMem = 1'b1;
    clks(10);
    arst_n = 1'b1;
    t_reset();
    t_phases();
    t_xmove(3'h0, 1'b0);
    t_xmove(3'h1, 1'b1);
    t_xmove(3'h7, 1'b0);
    t_idle();
    t_pdown();
    t_wdog();
    stop_test();
  end
endmodule // crpc_core_seq_tb
`default_nettype wire
